// [hw/smf_pkg.sv]
// package: register map, bit positions and timing constants of the supply monitor
package smf_pkg;
  // register word addresses (byte offsets on the wishbone bus)
  localparam logic [3:0] ADDR_MON_STAT_ONE = 4'h0;
  localparam logic [3:0] ADDR_MON_STAT_TWO = 4'h4;
  localparam logic [3:0] ADDR_SAFETY_STAT_ONE = 4'h8;
  localparam logic [3:0] ADDR_CONTROL = 4'hc;
  // monitor_status_one bit positions
  localparam int S1_MON_ANALOG = 2;
  localparam int S1_LOW_PUMP_UV = 3;
  localparam int S1_LOW_PUMP_OV = 4;
  localparam int S1_HIGH_PUMP_OV = 5;
  localparam int S1_BATT_UV = 6;
  localparam int S1_BATT_OV = 7;
  // monitor_status_two bit positions
  localparam int S2_CORE_UV = 0;
  localparam int S2_CORE_OV = 1;
  localparam int S2_IO_UV = 2;
  localparam int S2_IO_OV = 3;
  localparam int S2_CAN_UV = 4;
  localparam int S2_CAN_OV = 5;
  localparam int S2_PREREG_UV = 6;
  localparam int S2_PREREG_OV = 7;
  // safety_status_one bit positions
  localparam int SF_SENSOR_OV = 4;
  localparam int SF_SENSOR_UV = 5;
  // control register bit positions
  localparam int CTL_BATT_OV_MASK = 0;
  localparam int CTL_CORE_UNMASK = 1;
  localparam int CTL_TRACK_MODE = 2;
  localparam int CTL_DRIVE_EN = 3;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // interrupt registers: status, clear (write-only) and enable
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h0;
  localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h4;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h8;
  localparam logic [7:0] IRQ_BASE = 8'h10;
  localparam int IRQ_STANDBY = 0;
  localparam int IRQ_RESET = 1;
  localparam int IRQ_FLAG = 2;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  // comparator filter time and cycle count at 100 MHz
  localparam int CLK_MHZ = 100;
  localparam int FILTER_TIME_US = 15;
  localparam int FILTER_CYCLES = FILTER_TIME_US * CLK_MHZ;
  localparam int FILTER_W = 11;
  // device states
  typedef enum logic [1:0] {
    SMF_ACTIVE = 2'b00,
    SMF_RESET = 2'b01,
    SMF_STANDBY = 2'b10
  } smf_state_e;
endpackage : smf_pkg

// [hw/smf_filter.sv]
// module: two-flop synchroniser plus stable-time glitch filter for one comparator
module smf_filter (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // raw comparator and filtered level
  input wire logic raw_i,
  output logic filt_o
);
  logic sync0_r;
  logic sync1_r;
  logic [smf_pkg::FILTER_W-1:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync0_r <= 1'b0;
      sync1_r <= 1'b0;
    end else begin
      sync0_r <= raw_i;
      sync1_r <= sync0_r;
    end
  end

  // output follows the input only after it stood stable for the filter time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      filt_o <= 1'b0;
    end else if (sync1_r == filt_o) begin
      cnt_r <= '0;
    end else if (cnt_r == smf_pkg::FILTER_W'(smf_pkg::FILTER_CYCLES - 1)) begin
      cnt_r <= '0;
      filt_o <= sync1_r; // RL16
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule // smf_filter

// [hw/smf_top.sv]
// module: fault response of the multirail supply supervisor, wishbone slave
// Behaviour
// [RL1] battery undervoltage: status one bit 6, standby, reset and enable low
// [RL2] battery overvoltage: status one bit 7; reset state unless masked
// [RL3] prereg rail under/over: status two bits 6/7 only
// [RL4] can rail: uv bit 4; ov bit 5 and enable low
// [RL5] io rail uv: status two bit 2, reset state, both outputs low
// [RL6] io rail ov: status two bit 3, enable low, no state change
// [RL7] core rail uv: bit 0 always; reset and outputs only when unmasked
// [RL8] core rail ov: bit 1; enable low only when unmasked
// [RL9] sensor rail uv bit 5, ov bit 4; tracking or main reference
// [RL10] high pump ov: status one bit 5, standby, both outputs low
// [RL11] low pump uv: status one bit 3, nothing else
// [RL12] low pump ov: bit 4, dependent rails down, standby, outputs low
// [RL13] monitor analog rail fault: bit 2, power-on reset, standby
// [RL14] analog rail uv: power-on reset, standby; overvoltage ignored
// [RL15] flag reads one while supply out of band, zero when within
// [RL16] comparator outputs are glitch filtered before flags are set
// [RL17] standby causes beat reset causes; all flags still set
module smf_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // raw comparator outputs, high while the fault condition holds
  input wire logic batt_uv_i,
  input wire logic batt_ov_i,
  input wire logic prereg_uv_i,
  input wire logic prereg_ov_i,
  input wire logic can_uv_i,
  input wire logic can_ov_i,
  input wire logic io_uv_i,
  input wire logic io_ov_i,
  input wire logic core_uv_i,
  input wire logic core_ov_i,
  input wire logic sensor_main_uv_i,
  input wire logic sensor_main_ov_i,
  input wire logic sensor_track_uv_i,
  input wire logic sensor_track_ov_i,
  input wire logic high_pump_ov_i,
  input wire logic low_pump_uv_i,
  input wire logic low_pump_ov_i,
  input wire logic mon_analog_uv_i,
  input wire logic mon_analog_ov_i,
  input wire logic analog_uv_i,
  // device outputs
  output logic mcu_reset_out_n_o,
  output logic drive_enable_out_o,
  output logic power_on_reset_o,
  output logic rails_down_o,
  output logic [1:0] state_o,
  output logic irq_o
);
  localparam int NCMP = 20;

  logic [NCMP-1:0] raw;
  logic [NCMP-1:0] flt;
  logic [7:0] stat_one;
  logic [7:0] stat_two;
  logic [7:0] safety_one;
  logic [7:0] ctl_r;
  logic [7:0] irq_stat_r;
  logic [7:0] irq_en_r;
  logic [7:0] irq_ev;
  logic [7:0] flags_prev_r;
  logic standby_req;
  logic reset_req;
  logic drive_enable_out_kill;
  logic sensor_uv;
  logic sensor_ov;
  logic wr_stb;
  logic rd_stb;
  logic ack_r;
  smf_pkg::smf_state_e state_r;
  smf_pkg::smf_state_e state_nxt;

  assign raw = {analog_uv_i, mon_analog_ov_i, mon_analog_uv_i,
                low_pump_ov_i, low_pump_uv_i, high_pump_ov_i,
                sensor_track_ov_i, sensor_track_uv_i,
                sensor_main_ov_i, sensor_main_uv_i,
                core_ov_i, core_uv_i, io_ov_i, io_uv_i,
                can_ov_i, can_uv_i, prereg_ov_i, prereg_uv_i,
                batt_ov_i, batt_uv_i};

  // one filter per comparator, each with its own synchroniser
  genvar g;
  generate
    for (g = 0; g < NCMP; g++) begin : g_flt
      smf_filter u_flt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i(raw[g]),
        .filt_o(flt[g])
      );
    end
  endgenerate

  // filtered level names
  logic f_batt_uv, f_batt_ov, f_pre_uv, f_pre_ov, f_can_uv, f_can_ov;
  logic f_io_uv, f_io_ov, f_core_uv, f_core_ov, f_hp_ov, f_lp_uv, f_lp_ov;
  logic f_ma_uv, f_ma_ov, f_an_uv;
  assign f_batt_uv = flt[0];
  assign f_batt_ov = flt[1];
  assign f_pre_uv = flt[2];
  assign f_pre_ov = flt[3];
  assign f_can_uv = flt[4];
  assign f_can_ov = flt[5];
  assign f_io_uv = flt[6];
  assign f_io_ov = flt[7];
  assign f_core_uv = flt[8];
  assign f_core_ov = flt[9];
  assign f_hp_ov = flt[14];
  assign f_lp_uv = flt[15];
  assign f_lp_ov = flt[16];
  assign f_ma_uv = flt[17];
  assign f_ma_ov = flt[18];
  assign f_an_uv = flt[19];

  // sensor rail compares against tracking input or main reference
  assign sensor_uv = ctl_r[smf_pkg::CTL_TRACK_MODE] ? flt[12] : flt[10]; // RL9
  assign sensor_ov = ctl_r[smf_pkg::CTL_TRACK_MODE] ? flt[13] : flt[11]; // RL9

  // flags are live levels: set while out of band, clear when back in
  always_comb begin
    stat_one = 8'h00;
    stat_two = 8'h00;
    safety_one = 8'h00;
    stat_one[smf_pkg::S1_BATT_UV] = f_batt_uv; // RL1 RL15
    stat_one[smf_pkg::S1_BATT_OV] = f_batt_ov; // RL2
    stat_one[smf_pkg::S1_HIGH_PUMP_OV] = f_hp_ov; // RL10
    stat_one[smf_pkg::S1_LOW_PUMP_UV] = f_lp_uv; // RL11
    stat_one[smf_pkg::S1_LOW_PUMP_OV] = f_lp_ov; // RL12
    stat_one[smf_pkg::S1_MON_ANALOG] = f_ma_uv | f_ma_ov; // RL13
    stat_two[smf_pkg::S2_PREREG_UV] = f_pre_uv; // RL3
    stat_two[smf_pkg::S2_PREREG_OV] = f_pre_ov; // RL3
    stat_two[smf_pkg::S2_CAN_UV] = f_can_uv; // RL4
    stat_two[smf_pkg::S2_CAN_OV] = f_can_ov; // RL4
    stat_two[smf_pkg::S2_IO_UV] = f_io_uv; // RL5
    stat_two[smf_pkg::S2_IO_OV] = f_io_ov; // RL6
    stat_two[smf_pkg::S2_CORE_UV] = f_core_uv; // RL7
    stat_two[smf_pkg::S2_CORE_OV] = f_core_ov; // RL8
    safety_one[smf_pkg::SF_SENSOR_UV] = sensor_uv; // RL9
    safety_one[smf_pkg::SF_SENSOR_OV] = sensor_ov; // RL9
  end

  // power-on reset from the analog rails; analog overvoltage has no input
  assign power_on_reset_o = f_ma_uv | f_ma_ov | f_an_uv; // RL13 RL14

  // low pump overvoltage takes the can, io and core rails out of service
  assign rails_down_o = f_lp_ov; // RL12

  assign standby_req = f_batt_uv | f_hp_ov | f_lp_ov // RL1 RL10 RL12
                       | power_on_reset_o; // RL13 RL14

  assign reset_req = (f_batt_ov & ~ctl_r[smf_pkg::CTL_BATT_OV_MASK]) // RL2
                     | f_io_uv // RL5
                     | (f_core_uv & ctl_r[smf_pkg::CTL_CORE_UNMASK]); // RL7

  // enable-only kills; prereg and low pump uv do not appear here
  assign drive_enable_out_kill = f_can_ov // RL4
                      | f_io_ov // RL6
                      | (f_core_ov & ctl_r[smf_pkg::CTL_CORE_UNMASK]); // RL8

  // states are held only while a cause stands; release returns to active
  always_comb begin
    case (state_r)
      smf_pkg::SMF_ACTIVE,
      smf_pkg::SMF_RESET,
      smf_pkg::SMF_STANDBY: begin
        if (standby_req) begin
          state_nxt = smf_pkg::SMF_STANDBY; // RL17
        end else if (reset_req) begin
          state_nxt = smf_pkg::SMF_RESET;
        end else begin
          state_nxt = smf_pkg::SMF_ACTIVE;
        end
      end
      default: state_nxt = smf_pkg::SMF_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= smf_pkg::SMF_STANDBY;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign state_o = state_r;

  // reset output held low outside active, enable further gated by kills
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mcu_reset_out_n_o <= 1'b0;
      drive_enable_out_o <= 1'b0;
    end else begin
      mcu_reset_out_n_o <= (state_nxt == smf_pkg::SMF_ACTIVE); // RL1 RL5
      drive_enable_out_o <= (state_nxt == smf_pkg::SMF_ACTIVE)
                            & ~drive_enable_out_kill // RL4 RL6 RL8
                            & ctl_r[smf_pkg::CTL_DRIVE_EN];
    end
  end

  // interrupt events: entry into standby, into reset, any bit rising in the OR of the three flag registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_prev_r <= 8'h00;
    end else begin
      flags_prev_r <= stat_one | stat_two | safety_one;
    end
  end

  always_comb begin
    irq_ev = 8'h00;
    irq_ev[smf_pkg::IRQ_STANDBY] = (state_nxt == smf_pkg::SMF_STANDBY)
                                   & (state_r != smf_pkg::SMF_STANDBY);
    irq_ev[smf_pkg::IRQ_RESET] = (state_nxt == smf_pkg::SMF_RESET)
                                 & (state_r != smf_pkg::SMF_RESET);
    irq_ev[smf_pkg::IRQ_FLAG] = |((stat_one | stat_two | safety_one)
                                  & ~flags_prev_r);
  end

  // wishbone: one wait state, ack is a registered single-cycle pulse
  assign wr_stb = cyc_i & stb_i & we_i & ~ack_r & sel_i[0];
  assign rd_stb = cyc_i & stb_i & ~we_i & ~ack_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= cyc_i & stb_i & ~ack_r;
    end
  end

  assign ack_o = ack_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r <= smf_pkg::CTL_RESET;
    end else if (wr_stb && adr_i == smf_pkg::ADDR_CONTROL) begin
      ctl_r <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_r <= smf_pkg::IRQ_EN_RESET;
    end else if (wr_stb && sel_i[1] && adr_i == smf_pkg::ADDR_IRQ_EN) begin
      irq_en_r <= dat_i[7:0];
    end
  end

  // an event in the clear cycle survives: set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= 8'h00;
    end else if (wr_stb && sel_i[1] && adr_i == smf_pkg::ADDR_IRQ_CLEAR) begin
      irq_stat_r <= (irq_stat_r & ~dat_i[7:0]) | irq_ev;
    end else begin
      irq_stat_r <= irq_stat_r | irq_ev;
    end
  end

  assign irq_o = |(irq_stat_r & irq_en_r);

  // read mux; sel_i[1] picks the irq bank
  // limitation: the 4-bit address window folds the irq bank onto a page
  // chosen by sel_i[1]; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_stb) begin
      if (sel_i[1]) begin
        case (adr_i)
          smf_pkg::ADDR_IRQ_STAT: dat_o <= {24'h00_0000, irq_stat_r};
          smf_pkg::ADDR_IRQ_EN: dat_o <= {24'h00_0000, irq_en_r};
          default: dat_o <= 32'h0000_0000;
        endcase
      end else begin
        case (adr_i)
          smf_pkg::ADDR_MON_STAT_ONE: dat_o <= {24'h00_0000, stat_one};
          smf_pkg::ADDR_MON_STAT_TWO: dat_o <= {24'h00_0000, stat_two};
          smf_pkg::ADDR_SAFETY_STAT_ONE: dat_o <= {24'h00_0000, safety_one};
          smf_pkg::ADDR_CONTROL: dat_o <= {24'h00_0000, ctl_r};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end else begin
      dat_o <= 32'h0000_0000;
    end
  end
endmodule // smf_top

// [sim/smf_top_sva.sv]
// checker: port-level assertions for the supply monitor fault response
module smf_top_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // raw sources of power-on reset
  input wire logic mon_analog_uv_i,
  input wire logic mon_analog_ov_i,
  input wire logic analog_uv_i,
  // device outputs
  input wire logic mcu_reset_out_n_o,
  input wire logic drive_enable_out_o,
  input wire logic power_on_reset_o,
  input wire logic rails_down_o,
  input wire logic [1:0] state_o,
  input wire logic irq_o
);
  logic [11:0] held_r;
  // cycles a power-on-reset source has stayed high; saturates
  always_ff @(posedge clk_i) begin
    if (rst_i || !(mon_analog_uv_i || mon_analog_ov_i || analog_uv_i)) begin
      held_r <= 12'h0;
    end else if (held_r != 12'hfff) begin
      held_r <= held_r + 12'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence bus_ans;
    ack_o ##1 !ack_o;
  endsequence
  bus_answer_a: assert property (bus_req |=> bus_ans)
    else $error("bus request not answered as one pulse");
  read_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside ack");
  reset_tie_a: assert property (mcu_reset_out_n_o == (state_o == 2'b00))
    else $error("mcu reset output disagrees with state");
  enable_off_a: assert property (state_o != 2'b00 |-> !drive_enable_out_o)
    else $error("drive enable high outside active");
  por_standby_a: assert property (power_on_reset_o |=> state_o == 2'b10)
    else $error("power-on reset did not give standby");
  rails_standby_a: assert property
    (rails_down_o |=> state_o == 2'b10 && !mcu_reset_out_n_o)
    else $error("low pump overvoltage did not give standby");
  filter_wait_a: assert property
    ($rose(power_on_reset_o) |-> held_r >= 12'd1490)
    else $error("power-on reset rose before filter time");
  reset_values_a: assert property (disable iff (1'b0) rst_i |=>
    state_o == 2'b10 && !mcu_reset_out_n_o && !drive_enable_out_o
    && !irq_o && !ack_o)
    else $error("wrong output values in reset");
endmodule // smf_top_chk

bind smf_top smf_top_chk u_smf_top_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .dat_o(dat_o), .ack_o(ack_o), .mon_analog_uv_i(mon_analog_uv_i),
  .mon_analog_ov_i(mon_analog_ov_i), .analog_uv_i(analog_uv_i),
  .mcu_reset_out_n_o(mcu_reset_out_n_o),
  .drive_enable_out_o(drive_enable_out_o),
  .power_on_reset_o(power_on_reset_o), .rails_down_o(rails_down_o),
  .state_o(state_o), .irq_o(irq_o));

// [sim/smf_mcu_model.sv]
// far-side microcontroller: wishbone master that reads flags, sets control
module smf_mcu_model (
  // clock
  input wire logic clk_i,
  // bus answer
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  // bus request
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [3:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 4'h0;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // one classic cycle; a dead slave is left to the bench watchdog
  task automatic xfer(input logic w, input logic [3:0] a,
    input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    // released data must not keep looking valid
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule // smf_mcu_model

// [sim/tb_smf_top.sv]
// self-checking bench for the supply monitor fault response
module tb_smf_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [19:0] f = 20'h0;
  logic cyc, stb, we, ack, rst_n, en, por, rdn, irq;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, q;
  logic [1:0] st;
  int ctl = 0;
  int err_total = 0;
  int comparisons = 0;
  always #5 clk_i = ~clk_i;
  smf_mcu_model u_mcu (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
    .dat_o(wdat));
  smf_top u_smf_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .batt_uv_i(f[0]), .batt_ov_i(f[1]),
    .prereg_uv_i(f[2]), .prereg_ov_i(f[3]), .can_uv_i(f[4]),
    .can_ov_i(f[5]), .io_uv_i(f[6]), .io_ov_i(f[7]), .core_uv_i(f[8]),
    .core_ov_i(f[9]), .sensor_main_uv_i(f[10]), .sensor_main_ov_i(f[11]),
    .sensor_track_uv_i(f[12]), .sensor_track_ov_i(f[13]),
    .high_pump_ov_i(f[14]), .low_pump_uv_i(f[15]), .low_pump_ov_i(f[16]),
    .mon_analog_uv_i(f[17]), .mon_analog_ov_i(f[18]),
    .analog_uv_i(f[19]), .mcu_reset_out_n_o(rst_n),
    .drive_enable_out_o(en), .power_on_reset_o(por), .rails_down_o(rdn),
    .state_o(st), .irq_o(irq));
  // k: 0..2 status registers, 3 state, 4 reset, 5 enable, 6 por, 7 rails
  function automatic int model(input int k);
    int r[8];
    logic sb, rs;
    sb = f[0] | f[14] | f[16] | f[17] | f[18] | f[19];
    rs = (f[1] & !ctl[0]) | f[6] | (f[8] & ctl[1]);
    r[0] = (f[17] | f[18]) << 2 | f[15] << 3 | f[16] << 4 | f[14] << 5
      | f[0] << 6 | f[1] << 7;
    r[1] = f[8] | f[9] << 1 | f[6] << 2 | f[7] << 3 | f[4] << 4
      | f[5] << 5 | f[2] << 6 | f[3] << 7;
    r[2] = (ctl[2] ? f[12] : f[10]) << 5 | (ctl[2] ? f[13] : f[11]) << 4;
    r[3] = sb ? 2 : (rs ? 1 : 0);
    r[4] = !(sb | rs);
    r[5] = !(sb | rs | f[5] | f[7] | (f[9] & ctl[1]) | !ctl[3]);
    r[6] = f[17] | f[18] | f[19];
    r[7] = f[16];
    return r[k];
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic set_ctl(input int c);
    ctl = c;
    u_mcu.xfer(1'b1, 4'hc, 4'h1, 32'(c), q);
    u_mcu.xfer(1'b0, 4'hc, 4'h1, 32'h0, q);
    cmp(q, 32'(c));
  endtask
  // waits out the filter, then compares every result with the model
  task automatic check_all();
    repeat (1520) @(posedge clk_i);
    // pins are looked at mid-cycle, away from the edge that launches them
    @(negedge clk_i);
    cmp({30'h0, st}, 32'(model(3)));
    cmp({31'h0, rst_n}, 32'(model(4)));
    cmp({31'h0, en}, 32'(model(5)));
    cmp({31'h0, por}, 32'(model(6)));
    cmp({31'h0, rdn}, 32'(model(7)));
    @(posedge clk_i);
    for (int k = 0; k < 3; k++) begin
      u_mcu.xfer(1'b0, 4'(4 * k), 4'h1, 32'h0, q);
      cmp(q, 32'(model(k)));
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #900_000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(77181));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    u_mcu.xfer(1'b1, 4'h8, 4'h3, 32'h4, q);
    // each source alone, only drive enable set (core masked), then all control bits on
    for (int j = 0; j < 40; j++) begin
      set_ctl(j < 20 ? 8 : 15);
      f <= 20'h1 << (j % 20);
      check_all();
    end
    repeat (6) begin
      set_ctl($urandom_range(15));
      f <= 20'($urandom & $urandom & $urandom);
      check_all();
    end
    f <= 20'h0;
    check_all();
    // clear sticky bits first, so a flag raised by the short pulse shows
    u_mcu.xfer(1'b1, 4'h4, 4'h3, 32'h7, q);
    @(negedge clk_i);
    cmp({31'h0, irq}, 32'h0);
    @(posedge clk_i);
    // pulse just under the filter time must leave no trace
    f <= 20'h0_4000;
    repeat (1400) @(posedge clk_i);
    f <= 20'h0;
    check_all();
    @(negedge clk_i);
    cmp({31'h0, irq}, 32'h0);
    @(posedge clk_i);
    u_mcu.xfer(1'b1, 4'h8, 4'h3, 32'h0, q);
    f <= 20'h0_8000;
    check_all();
    @(negedge clk_i);
    cmp({31'h0, irq}, 32'h0);
    @(posedge clk_i);
    u_mcu.xfer(1'b0, 4'h0, 4'h3, 32'h0, q);
    cmp(q, 32'h4);
    u_mcu.xfer(1'b0, 4'h4, 4'h3, 32'h0, q);
    cmp(q, 32'h0);
    u_mcu.xfer(1'b1, 4'h8, 4'h3, 32'h4, q);
    @(negedge clk_i);
    cmp({31'h0, irq}, 32'h1);
    @(posedge clk_i);
    u_mcu.xfer(1'b1, 4'h4, 4'h3, 32'h4, q);
    @(negedge clk_i);
    cmp({31'h0, irq}, 32'h0);
    tally_and_finish();
  end
endmodule // tb_smf_top
